// File: mie_exec.sv
`timescale 1ns/1ps
// Behaviour
// - Both pre-clears executed: watchdog to zero, expired and sleep flags cleared.
// - A lone pre-clear only records itself; counter and both flags unchanged.
// - Invert-to-memory complements the data byte, updates zero only.
// - Invert-to-accumulator writes complement to accumulator, memory kept, zero only.
// - Decimal adjust low nibble: above 9 or half carry adds 6, makes nibble carry.
// - High nibble plus carry above 9 or carry adds 6, sets carry; to memory.
// - Count-down subtracts one, updates zero; accumulator variant leaves memory.
// - Count-up adds one, updates zero; accumulator variant leaves memory.
// - Sleep advances counter by one, stops execution, clock off, state kept.
// - Sleep clears watchdog and prescaler, sets sleep flag, clears expired.
// - Jump loads program counter from instruction, flags untouched.
// - Moves copy immediate, memory or accumulator without changing flags.
// - Idle only advances program counter by one, flags untouched.
// - Inclusive OR into accumulator or memory, updates zero only.
// - Subroutine return pops program counter, two instruction cycles, no flags.
// - Return-with-value pops counter and loads immediate into accumulator.
// - Interrupt return pops counter and sets global interrupt enable.
// - Left rotate moves bit 7 into bit 0 of memory, no flags.
// - Left rotate to accumulator keeps memory, no flags.
// - Rotate through carry: old bit 7 to carry, old carry to bit 0.
// - Instruction cycle is four clocks; extra flag adds one cycle except on returns, which take two cycles either way.
module mie_exec (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire mie_pkg::mie_req_t req,
    input wire logic wake_pin,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    output logic busy,
    output logic done,
    output mie_pkg::mie_mem_wr_t mem_wr,
    output logic [7:0] acc,
    output logic [9:0] pc,
    output logic sys_clk_off
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [8:0] daa_calc(input logic [7:0] a, input logic hc,
                                            input logic c);
        logic [4:0] lo;
        logic [4:0] hi;
        logic cout;
        begin
            lo = {1'b0, a[3:0]};
            if (a[3:0] > mie_pkg::BCD_MAX || hc) begin
                lo = lo + {1'b0, mie_pkg::BCD_FIX};
            end
            hi = {1'b0, a[7:4]} + {4'h0, lo[4]};
            cout = c;
            if (hi > {1'b0, mie_pkg::BCD_MAX} || c) begin
                hi = hi + {1'b0, mie_pkg::BCD_FIX};
                cout = 1'b1;
            end
            daa_calc = {cout, hi[3:0], lo[3:0]};
        end
    endfunction

    function automatic logic [8:0] rot_carry(input logic [7:0] m, input logic c);
        rot_carry = {m[7], m[6:0], c};
    endfunction

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SLEEP} mie_state_t;

    mie_state_t state_reg;
    mie_pkg::mie_req_t req_q;
    logic [1:0] phase_reg;
    logic [1:0] cyc_left_reg;
    logic carry_reg, half_carry_flag, zero_reg, global_irq_enable;
    logic watchdog_expired_flag, sleep_entered_flag;
    logic first_seen_reg, second_seen_reg;
    logic [7:0] watchdog_counter, presc_reg;
    logic [9:0] stack0_reg, stack1_reg;
    logic wake_meta_reg, wake_sync_reg;
    logic commit;
    logic [7:0] res;
    logic to_acc, to_mem, z_upd, c_upd, c_res;
    logic pair_done, wdt_clear, presc_wrap;

    assign commit = (state_reg == ST_EXEC) && (phase_reg == mie_pkg::PHASE_LAST)
                    && (cyc_left_reg == mie_pkg::CYC_ONE);
    assign pair_done = commit && ((req_q.op == mie_pkg::preclear_first && second_seen_reg)
                    || (req_q.op == mie_pkg::preclear_second && first_seen_reg));
    assign wdt_clear = pair_done || (commit && req_q.op == mie_pkg::sleep_op);
    assign presc_wrap = (presc_reg == mie_pkg::PRESC_LAST);

    // ************************************************************
    // Result datapath
    // ************************************************************
    always_comb begin
        logic [8:0] w;
        w = 9'h000;
        res = 8'h00;
        to_acc = 1'b0;
        to_mem = 1'b0;
        z_upd = 1'b0;
        c_upd = 1'b0;
        c_res = carry_reg;
        case (req_q.op)
            mie_pkg::invert_to_mem: begin
                res = ~req_q.mem_rdata;
                to_mem = 1'b1;
                z_upd = 1'b1;
            end
            mie_pkg::invert_to_acc: begin
                res = ~req_q.mem_rdata;
                to_acc = 1'b1;
                z_upd = 1'b1;
            end
            mie_pkg::decimal_adjust: begin
                w = daa_calc(acc, half_carry_flag, carry_reg);
                res = w[7:0];
                c_res = w[8];
                c_upd = 1'b1;
                to_mem = 1'b1;
            end
            mie_pkg::count_down_op, mie_pkg::count_down_to_acc: begin
                res = req_q.mem_rdata - 8'h01;
                to_mem = (req_q.op == mie_pkg::count_down_op);
                to_acc = ~to_mem;
                z_upd = 1'b1;
            end
            mie_pkg::count_up_op, mie_pkg::count_up_to_acc: begin
                res = req_q.mem_rdata + 8'h01;
                to_mem = (req_q.op == mie_pkg::count_up_op);
                to_acc = ~to_mem;
                z_upd = 1'b1;
            end
            mie_pkg::copy_imm_to_acc, mie_pkg::return_with_value: begin
                res = req_q.imm;
                to_acc = 1'b1;
            end
            mie_pkg::copy_mem_to_acc: begin
                res = req_q.mem_rdata;
                to_acc = 1'b1;
            end
            mie_pkg::copy_acc_to_mem: begin
                res = acc;
                to_mem = 1'b1;
            end
            mie_pkg::or_mem_to_acc, mie_pkg::or_imm_to_acc, mie_pkg::inclusive_into_ram: begin
                if (req_q.op == mie_pkg::or_imm_to_acc) begin
                    res = acc | req_q.imm;
                end else begin
                    res = acc | req_q.mem_rdata;
                end
                to_mem = (req_q.op == mie_pkg::inclusive_into_ram);
                to_acc = ~to_mem;
                z_upd = 1'b1;
            end
            mie_pkg::spin_left, mie_pkg::spin_left_to_acc: begin
                res = {req_q.mem_rdata[6:0], req_q.mem_rdata[7]};
                to_mem = (req_q.op == mie_pkg::spin_left);
                to_acc = ~to_mem;
            end
            mie_pkg::spin_left_via_carry, mie_pkg::spin_left_via_carry_to_acc: begin
                w = rot_carry(req_q.mem_rdata, carry_reg);
                res = w[7:0];
                c_res = w[8];
                c_upd = 1'b1;
                to_mem = (req_q.op == mie_pkg::spin_left_via_carry);
                to_acc = ~to_mem;
            end
            default: begin
                res = 8'h00;
            end
        endcase
    end

    // ************************************************************
    // Sequencing
    // ************************************************************
    always_ff @(posedge core_clk) begin
        wake_meta_reg <= wake_pin;
        wake_sync_reg <= wake_meta_reg;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            phase_reg <= 2'h0;
            cyc_left_reg <= 2'h0;
            req_q <= '0;
            busy <= 1'b0;
            sys_clk_off <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (req.valid) begin
                        req_q <= req;
                        phase_reg <= 2'h0;
                        busy <= 1'b1;
                        state_reg <= ST_EXEC;
                        if (req.op == mie_pkg::subroutine_back
                            || req.op == mie_pkg::return_with_value
                            || req.op == mie_pkg::irq_back) begin
                            cyc_left_reg <= mie_pkg::CYC_RET;
                        end else if (req.extra) begin
                            cyc_left_reg <= mie_pkg::CYC_RET;
                        end else begin
                            cyc_left_reg <= mie_pkg::CYC_ONE;
                        end
                    end
                end
                ST_EXEC: begin
                    phase_reg <= phase_reg + 2'h1;
                    if (phase_reg == mie_pkg::PHASE_LAST) begin
                        cyc_left_reg <= cyc_left_reg - 2'h1;
                    end
                    if (commit && req_q.op == mie_pkg::sleep_op) begin
                        state_reg <= ST_SLEEP;
                        sys_clk_off <= 1'b1;
                    end else if (commit) begin
                        state_reg <= ST_IDLE;
                        busy <= 1'b0;
                    end
                end
                ST_SLEEP: begin
                    // Expiry or the wake pin end the sleep
                    if (wake_sync_reg || watchdog_expired_flag) begin
                        state_reg <= ST_IDLE;
                        sys_clk_off <= 1'b0;
                        busy <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            done <= 1'b0;
            mem_wr <= '0;
        end else begin
            done <= commit;
            mem_wr.we <= commit && to_mem;
            mem_wr.addr <= req_q.mem_addr;
            mem_wr.data <= res;
        end
    end

    // ************************************************************
    // Accumulator, flags, program counter, stack
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            acc <= mie_pkg::ACC_RST;
        end else if (commit && to_acc) begin
            acc <= res;
        end else if (reg_we && reg_addr == mie_pkg::REG_ACC) begin
            acc <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            carry_reg <= 1'b0;
            half_carry_flag <= 1'b0;
            zero_reg <= 1'b0;
            global_irq_enable <= 1'b0;
        end else if (commit) begin
            if (z_upd) begin
                zero_reg <= (res == 8'h00);
            end
            if (c_upd) begin
                carry_reg <= c_res;
            end
            if (req_q.op == mie_pkg::irq_back) begin
                global_irq_enable <= 1'b1;
            end
        end else if (reg_we && reg_addr == mie_pkg::REG_STATUS) begin
            carry_reg <= reg_wdata[mie_pkg::ST_C];
            half_carry_flag <= reg_wdata[mie_pkg::ST_HC];
            zero_reg <= reg_wdata[mie_pkg::ST_Z];
            global_irq_enable <= reg_wdata[mie_pkg::ST_GIE];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pc <= mie_pkg::PC_RST;
            stack0_reg <= mie_pkg::PC_RST;
            stack1_reg <= mie_pkg::PC_RST;
        end else if (commit) begin
            case (req_q.op)
                mie_pkg::goto_op: begin
                    pc <= req_q.target;
                end
                mie_pkg::subroutine_back, mie_pkg::return_with_value, mie_pkg::irq_back: begin
                    pc <= stack0_reg;
                    stack0_reg <= stack1_reg;
                end
                default: begin
                    pc <= pc + 10'h001;
                end
            endcase
        end else if (reg_we && reg_addr == mie_pkg::REG_PC_LO) begin
            pc <= {pc[9:8], reg_wdata};
        end else if (reg_we && reg_addr == mie_pkg::REG_PC_HI) begin
            pc <= {reg_wdata[1:0], pc[7:0]};
        end else if (reg_we && reg_addr == mie_pkg::REG_STACK) begin
            // Pushes the return address a call would leave behind
            stack1_reg <= stack0_reg;
            stack0_reg <= pc + 10'h001;
        end
    end

    // ************************************************************
    // Watchdog and pre-clear pairing
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            first_seen_reg <= 1'b0;
            second_seen_reg <= 1'b0;
        end else if (pair_done) begin
            first_seen_reg <= 1'b0;
            second_seen_reg <= 1'b0;
        end else if (commit && req_q.op == mie_pkg::preclear_first) begin
            first_seen_reg <= 1'b1;
        end else if (commit && req_q.op == mie_pkg::preclear_second) begin
            second_seen_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            presc_reg <= mie_pkg::WDT_CLEAR;
            watchdog_counter <= mie_pkg::WDT_CLEAR;
            watchdog_expired_flag <= 1'b0;
            sleep_entered_flag <= 1'b0;
        end else if (wdt_clear) begin
            presc_reg <= mie_pkg::WDT_CLEAR;
            watchdog_counter <= mie_pkg::WDT_CLEAR;
            watchdog_expired_flag <= 1'b0;
            sleep_entered_flag <= (req_q.op == mie_pkg::sleep_op);
        end else begin
            presc_reg <= presc_reg + 8'h01;
            if (presc_wrap) begin
                watchdog_counter <= watchdog_counter + 8'h01;
            end
            if (presc_wrap && watchdog_counter == mie_pkg::WDT_LAST) begin
                watchdog_expired_flag <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Register read port
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n || !reg_re) begin
            reg_rdata <= 8'h00;
        end else if (reg_addr == mie_pkg::REG_ACC) begin
            reg_rdata <= acc;
        end else if (reg_addr == mie_pkg::REG_STATUS) begin
            reg_rdata <= {2'h0, sleep_entered_flag, watchdog_expired_flag,
                          global_irq_enable, zero_reg, half_carry_flag, carry_reg};
        end else if (reg_addr == mie_pkg::REG_PC_LO) begin
            reg_rdata <= pc[7:0];
        end else if (reg_addr == mie_pkg::REG_PC_HI) begin
            reg_rdata <= {6'h00, pc[9:8]};
        end else if (reg_addr == mie_pkg::REG_WDT) begin
            reg_rdata <= watchdog_counter;
        end else if (reg_addr == mie_pkg::REG_STACK) begin
            reg_rdata <= stack0_reg[7:0];
        end else if (reg_addr == mie_pkg::REG_PRECLR) begin
            reg_rdata <= {6'h00, second_seen_reg, first_seen_reg};
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence one_cycle_s;
        !done [*4] ##1 done;
    endsequence

    sequence two_cycle_s;
        !done [*8] ##1 done;
    endsequence

    pair_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        done && req_q.op == mie_pkg::preclear_second && $past(first_seen_reg) |->
        watchdog_counter == 8'h00 && !watchdog_expired_flag && !sleep_entered_flag
        && !first_seen_reg && !second_seen_reg)
        else $error("pre-clear pair did not clear the watchdog");

    lone_preclear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        done && req_q.op == mie_pkg::preclear_first && !$past(second_seen_reg) |->
        first_seen_reg && sleep_entered_flag == $past(sleep_entered_flag))
        else $error("lone pre-clear changed the watchdog state");

    invert_mem_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        done && req_q.op == mie_pkg::invert_to_mem |->
        mem_wr.we && mem_wr.data == ~req_q.mem_rdata && zero_reg == (mem_wr.data == 8'h00))
        else $error("invert to memory wrong");

    invert_acc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        done && req_q.op == mie_pkg::invert_to_acc |-> !mem_wr.we && acc == ~req_q.mem_rdata)
        else $error("invert to accumulator wrong");

    decimal_adj_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        done && req_q.op == mie_pkg::decimal_adjust |->
        {carry_reg, mem_wr.data} == daa_calc($past(acc), $past(half_carry_flag),
        $past(carry_reg)) && zero_reg == $past(zero_reg))
        else $error("decimal adjust wrong");

    count_acc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        done && req_q.op == mie_pkg::count_down_to_acc |->
        !mem_wr.we && acc == req_q.mem_rdata - 8'h01)
        else $error("count down to accumulator wrong");

    sleep_entry_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        done && req_q.op == mie_pkg::sleep_op |-> sys_clk_off && sleep_entered_flag
        && !watchdog_expired_flag && pc == $past(pc) + 10'h001)
        else $error("sleep entry wrong");

    goto_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        done && req_q.op == mie_pkg::goto_op |-> pc == req_q.target && $stable(carry_reg))
        else $error("jump did not load target");

    ret_timing_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(busy) && req_q.op == mie_pkg::subroutine_back |-> two_cycle_s)
        else $error("subroutine return not two cycles");

    idle_timing_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(busy) && !req_q.extra && req_q.op != mie_pkg::subroutine_back
        && req_q.op != mie_pkg::return_with_value && req_q.op != mie_pkg::irq_back
        |-> one_cycle_s)
        else $error("single cycle not four clocks");

    irq_return_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        done && req_q.op == mie_pkg::irq_back |-> global_irq_enable && pc == $past(stack0_reg))
        else $error("interrupt return wrong");

    spin_carry_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        done && req_q.op == mie_pkg::spin_left_via_carry |->
        carry_reg == req_q.mem_rdata[7] && mem_wr.data == {req_q.mem_rdata[6:0],
        $past(carry_reg)})
        else $error("rotate through carry wrong");

endmodule // mie_exec

// File: mie_exec_tb_top.sv
`timescale 1ns/1ps
module mie_exec_tb_top;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    mie_pkg::mie_req_t req = '0;
    logic wake_pin = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [7:0] reg_rdata, acc, rdata, st;
    logic [9:0] pc;
    logic busy, done, sys_clk_off;
    mie_pkg::mie_mem_wr_t mem_wr;
    logic [5:0] raddr = 6'h00;
    int err_count = 0;
    int num_checks = 0;
    int n;
    always #12.5 core_clk = ~core_clk;
    mie_exec u_mie_exec (.core_clk(core_clk), .rst_n(rst_n), .req(req), .wake_pin(wake_pin),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .busy(busy), .done(done), .mem_wr(mem_wr), .acc(acc),
        .pc(pc), .sys_clk_off(sys_clk_off));
    mie_mem_model u_mie_mem_model (.core_clk(core_clk), .mem_wr(mem_wr), .raddr(raddr),
        .rdata(rdata));
    // ****************************************
    // Access tasks
    // ****************************************
    task automatic end_of_test;
        if (err_count == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge core_clk);
        #1 st = reg_rdata;
        reg_re <= 1'b0;
    endtask
    task automatic push;
        @(posedge core_clk);
        reg_addr <= mie_pkg::REG_STACK;
        reg_we <= 1'b1;
        @(posedge core_clk);
        #1 reg_we <= 1'b0;
    endtask
    // Sleep still pulses done but holds busy, so wake is raised after done
    task automatic ex(input mie_pkg::mie_op_t op, input logic [7:0] imm, input logic [5:0] a,
        input logic x = 1'b0);
        raddr = a;
        @(posedge core_clk);
        req <= '{1'b1, op, x, imm, rdata, a, {2'h1, imm}};
        @(posedge core_clk);
        #1 req.valid <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk("done", done, 1);
        if (op == mie_pkg::sleep_op) begin
            chk("clk_off", {busy, sys_clk_off}, 2'h3);
            wake_pin <= 1'b1;
            n = 0;
            while (busy !== 1'b0 && n < 40) begin
                @(posedge core_clk);
                #1 n++;
            end
            chk("woken", {busy, sys_clk_off}, 0);
            wake_pin <= 1'b0;
        end
        @(posedge core_clk);
        #1;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(mie_pkg::REG_ACC);
        chk("acc_rst", st, 0);
        ex(mie_pkg::copy_imm_to_acc, 8'h5a, 0);
        chk("mov", acc, 8'h5a);
        chk("cycles", n[9:0], 4);
        ex(mie_pkg::copy_acc_to_mem, 0, 3);
        ex(mie_pkg::invert_to_mem, 0, 3);
        chk("cpl", rdata, 8'ha5);
        ex(mie_pkg::invert_to_acc, 0, 3);
        chk("invert_to_acc", acc, 8'h5a);
        chk("invert_to_acc_mem", rdata, 8'ha5);
        ex(mie_pkg::copy_imm_to_acc, 8'h01, 0);
        ex(mie_pkg::copy_acc_to_mem, 0, 4);
        ex(mie_pkg::count_down_to_acc, 0, 4);
        chk("count_down_to_acc", {acc, rdata}, 10'h001);
        rd(mie_pkg::REG_STATUS);
        chk("z_set", st[mie_pkg::ST_Z], 1);
        ex(mie_pkg::count_up_op, 0, 4);
        rd(mie_pkg::REG_STATUS);
        chk("inc", {st[mie_pkg::ST_Z], rdata}, 10'h002);
        ex(mie_pkg::copy_imm_to_acc, 8'h90, 0);
        ex(mie_pkg::inclusive_into_ram, 0, 4);
        ex(mie_pkg::or_imm_to_acc, 8'h0b, 4);
        chk("or", {acc, rdata}, {8'h9b, 8'h92});
        ex(mie_pkg::decimal_adjust, 0, 5);
        rd(mie_pkg::REG_STATUS);
        chk("daa", {st[mie_pkg::ST_C], rdata}, 10'h101);
        ex(mie_pkg::spin_left, 0, 4);
        chk("rl", rdata, 8'h25);
        ex(mie_pkg::spin_left_to_acc, 0, 4);
        chk("rla", {acc, rdata}, {8'h4a, 8'h25});
        ex(mie_pkg::spin_left_via_carry, 0, 4);
        rd(mie_pkg::REG_STATUS);
        chk("rlc", {st[mie_pkg::ST_C], rdata}, 10'h04b);
        ex(mie_pkg::goto_op, 8'h55, 0);
        chk("jmp", pc, 10'h155);
        ex(mie_pkg::idle_op, 0, 0, 1'b1);
        chk("nop", pc, 10'h156);
        chk("extra", n[9:0], 8);
        push;
        ex(mie_pkg::subroutine_back, 0, 0);
        chk("ret", {pc, n[3:0]}, {10'h157, 4'h8});
        push;
        ex(mie_pkg::return_with_value, 8'h3c, 0);
        chk("retv", {pc, acc}, {10'h158, 8'h3c});
        push;
        ex(mie_pkg::irq_back, 0, 0);
        rd(mie_pkg::REG_STATUS);
        chk("irq_back", {pc, st[mie_pkg::ST_GIE]}, {10'h159, 1'b1});
        ex(mie_pkg::sleep_op, 0, 0);
        rd(mie_pkg::REG_STATUS);
        chk("halt", {pc, st[5:4]}, {10'h15a, 2'h2});
        ex(mie_pkg::preclear_first, 0, 0);
        rd(mie_pkg::REG_STATUS);
        chk("pre1", st[mie_pkg::ST_SLP], 1);
        rd(mie_pkg::REG_PRECLR);
        chk("pre1_seen", st, 8'h01);
        ex(mie_pkg::preclear_second, 0, 0);
        rd(mie_pkg::REG_STATUS);
        chk("pre2", st[5:4], 0);
        rd(mie_pkg::REG_PRECLR);
        chk("pre_rst", st, 0);
        ex(mie_pkg::copy_mem_to_acc, 0, 4);
        chk("mov_m", acc, 8'h4b);
        ex(mie_pkg::count_down_op, 0, 4);
        chk("dec", rdata, 8'h4a);
        ex(mie_pkg::count_up_to_acc, 0, 4);
        chk("count_up_to_acc", {acc, rdata}, {8'h4b, 8'h4a});
        ex(mie_pkg::or_mem_to_acc, 0, 3);
        chk("or_m", acc, 8'hef);
        ex(mie_pkg::spin_left_via_carry_to_acc, 0, 4);
        chk("rlca", {acc, rdata}, {8'h94, 8'h4a});
        end_of_test;
    end
    initial begin
        #100us;
        err_count++;
        end_of_test;
    end
endmodule // mie_exec_tb_top

// File: mie_mem_model.sv
`timescale 1ns/1ps
// ****************************************
// Data memory behind the datapath
// ****************************************
module mie_mem_model (
    input wire logic core_clk,
    input wire mie_pkg::mie_mem_wr_t mem_wr,
    input wire logic [5:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem_reg [64];
    always_ff @(posedge core_clk) begin
        if (mem_wr.we) begin
            mem_reg[mem_wr.addr] <= mem_wr.data;
        end
    end
    // Read is combinational so the bench hands the byte over with the request
    assign rdata = mem_reg[raddr];
endmodule // mie_mem_model

// File: mie_pkg.sv
package mie_pkg;

    // ************************************************************
    // Widths and timing
    // ************************************************************
    localparam int DATA_W = 8;
    localparam int PC_W = 10;
    localparam int MADDR_W = 6;
    localparam int RADDR_W = 4;
    // Four system clocks make one instruction cycle
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_RET = 2'h2;
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [3:0] BCD_FIX = 4'h6;
    localparam logic [7:0] WDT_CLEAR = 8'h00;
    localparam logic [7:0] WDT_LAST = 8'hff;
    localparam logic [7:0] PRESC_LAST = 8'hff;

    // ************************************************************
    // Register map and reset values
    // ************************************************************
    localparam logic [3:0] REG_ACC = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_PC_LO = 4'h2;
    localparam logic [3:0] REG_PC_HI = 4'h3;
    localparam logic [3:0] REG_WDT = 4'h4;
    localparam logic [3:0] REG_STACK = 4'h5;
    localparam logic [3:0] REG_PRECLR = 4'h6;
    localparam int ST_C = 0;
    localparam int ST_HC = 1;
    localparam int ST_Z = 2;
    localparam int ST_GIE = 3;
    localparam int ST_EXP = 4;
    localparam int ST_SLP = 5;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [9:0] PC_RST = 10'h000;

    // ************************************************************
    // Operations and carriers
    // ************************************************************
    typedef enum logic [4:0] {
        idle_op, preclear_first, preclear_second, invert_to_mem, invert_to_acc,
        decimal_adjust, count_down_op, count_down_to_acc, count_up_op, count_up_to_acc,
        sleep_op, goto_op, copy_imm_to_acc, copy_mem_to_acc, copy_acc_to_mem,
        or_mem_to_acc, or_imm_to_acc, inclusive_into_ram, subroutine_back,
        return_with_value, irq_back, spin_left, spin_left_to_acc, spin_left_via_carry,
        spin_left_via_carry_to_acc
    } mie_op_t;

    typedef struct packed {
        logic valid;
        mie_op_t op;
        logic extra;
        logic [7:0] imm;
        logic [7:0] mem_rdata;
        logic [5:0] mem_addr;
        logic [9:0] target;
    } mie_req_t;

    typedef struct packed {
        logic we;
        logic [5:0] addr;
        logic [7:0] data;
    } mie_mem_wr_t;

endpackage
